// ### motpot_counter.sv
/*
 * Ramped up/down reference counter with configurable limits and ramp time.
 * Assumes configuration ports are static or change from same-clock logic,
 * and that the up and down commands arrive asynchronously from pins.
 */
`include "motpot_params.svh"

module motpot_counter #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_up,
    input wire logic i_down,
    input wire motpot_pkg::mode_t i_mode,
    input wire logic i_power_up,
    input wire logic [WIDTH-1:0] i_init,
    input wire logic [WIDTH-1:0] i_min,
    input wire logic [WIDTH-1:0] i_max,
    input wire logic [15:0] i_ramp_ms,
    output motpot_pkg::ref_out_t o_ref
);
    import motpot_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    if (WIDTH != 16) begin : g_bad_width
        $error("WIDTH must match the 16-bit reference output.");
    end

    logic up_s1_q;
    logic up_q;
    logic dn_s1_q;
    logic dn_q;
    state_t state_q;
    logic [WIDTH-1:0] count_q;
    logic enabled;
    logic run;
    logic step;
    logic [WIDTH-1:0] span;
    logic [WIDTH-1:0] init_c;

    // Limits the given value into the configured window.
    function automatic logic [WIDTH-1:0] clamp(input logic [WIDTH-1:0] v,
                                               input logic [WIDTH-1:0] lo,
                                               input logic [WIDTH-1:0] hi);
        logic [WIDTH-1:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end
        if (r < lo) begin
            r = lo;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // The up and down commands come from pins and pass two flip-flops.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_s1_q <= 1'b0;
            up_q <= 1'b0;
            dn_s1_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_s1_q <= i_up;
            up_q <= up_s1_q;
            dn_s1_q <= i_down;
            dn_q <= dn_s1_q;
        end
    end

    // ------------------------------------------------------------------------
    // Rate generation
    // ------------------------------------------------------------------------
    // Motion is requested only for one direction alone; both together hold.
    assign enabled = (i_mode != MODE_DISABLED);
    assign run = enabled && (state_q == ST_RUN) && !i_power_up
                 && (up_q ^ dn_q);
    assign span = (i_max > i_min) ? (i_max - i_min) : '0;
    assign init_c = clamp(i_init, i_min, i_max);

    motpot_rate_gen #(
        .WIDTH(WIDTH)
    ) u_rate (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(run),
        .i_span(span),
        .i_ramp_ms(i_ramp_ms),
        .o_step(step)
    );

    // ------------------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------------------
    // A load state sits between enabling and running, so no step can
    // overtake the initial value.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (enabled) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state_q <= enabled ? ST_RUN : ST_OFF;
                end
                ST_RUN: begin
                    if (!enabled) begin
                        state_q <= ST_OFF;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Count register
    // ------------------------------------------------------------------------
    // Only a cold reset clears the count; a power-up pulse reloads it in
    // reload mode and leaves it alone in retain mode.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= `MOTPOT_REF_RST;
        end else if (state_q == ST_LOAD) begin
            count_q <= init_c;
        end else if (state_q == ST_RUN && i_power_up) begin
            if (i_mode == MODE_RESET_PU) begin
                count_q <= init_c;
            end
        end else if (state_q == ST_RUN && step && up_q && !dn_q) begin
            count_q <= (count_q >= i_max) ? i_max
                       : count_q + 1'b1;
        end else if (state_q == ST_RUN && step && dn_q && !up_q) begin
            count_q <= (count_q <= i_min) ? i_min
                       : count_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Reference output
    // ------------------------------------------------------------------------
    // The value comes straight from the count flip-flops.
    assign o_ref.value = count_q;
    assign o_ref.active = (state_q == ST_RUN);
    assign o_ref.at_min = (count_q == i_min);
    assign o_ref.at_max = (count_q == i_max);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_enable_rise;
        (state_q == ST_OFF) && enabled ##1 (state_q == ST_LOAD);
    endsequence

    property p_load_on_enable;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_enable_rise ##1 enabled |-> (count_q == $past(init_c));
    endproperty
    a_load_on_enable: assert property (p_load_on_enable)
        else $error("Count did not take the initial value on enable.");

    property p_hold_both;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && up_q && dn_q && !i_power_up && enabled)
            |=> $stable(count_q);
    endproperty
    a_hold_both: assert property (p_hold_both)
        else $error("Count moved with both commands active.");

    property p_up_step;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && step && up_q && !dn_q && !i_power_up
         && count_q < i_max) |=> count_q == $past(count_q) + 1'b1;
    endproperty
    a_up_step: assert property (p_up_step)
        else $error("Up step did not raise the count by one.");

    property p_down_step;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && step && dn_q && !up_q && !i_power_up
         && count_q > i_min) |=> count_q == $past(count_q) - 1'b1;
    endproperty
    a_down_step: assert property (p_down_step)
        else $error("Down step did not lower the count by one.");

    property p_limits;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && i_min <= i_max && $stable(i_min)
         && $stable(i_max) && $past(state_q) == ST_RUN)
            |-> (count_q >= i_min && count_q <= i_max);
    endproperty
    a_limits: assert property (p_limits)
        else $error("Count left the configured window.");

    property p_retain_pu;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && i_power_up && i_mode == MODE_RETAIN)
            |=> $stable(count_q);
    endproperty
    a_retain_pu: assert property (p_retain_pu)
        else $error("Count changed at power-up in retain mode.");

    property p_reload_pu;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN && i_power_up && i_mode == MODE_RESET_PU)
            |=> count_q == $past(init_c);
    endproperty
    a_reload_pu: assert property (p_reload_pu)
        else $error("Count not reloaded at power-up in reload mode.");

    // Raising at the top must leave the value pinned at the maximum.
    property p_out_flags;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_ref.at_max && state_q == ST_RUN && up_q && !dn_q && !i_power_up)
            |=> o_ref.value == $past(i_max);
    endproperty
    a_out_flags: assert property (p_out_flags)
        else $error("Count moved past the maximum while raised.");
endmodule

// ### motpot_params.svh
/*
 * Timing counts and reset values for the ramped up/down reference counter.
 * Assumes a single 100 MHz system clock.
 */
`ifndef MOTPOT_PARAMS_SVH
`define MOTPOT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MOTPOT_CLK_PERIOD_NS 10
`define MOTPOT_MS_IN_NS 1000000
`define MOTPOT_CYC_PER_MS (`MOTPOT_MS_IN_NS / `MOTPOT_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Reset values and accumulator width
// ----------------------------------------------------------------------------
`define MOTPOT_REF_RST 16'h0000
`define MOTPOT_ACC_W 40

`endif

// ### motpot_pkg.sv
/*
 * Types shared by the reference counter and its rate generator.
 * Assumes nothing of its surroundings.
 */
package motpot_pkg;

    // ------------------------------------------------------------------------
    // Function mode: off, on with reload at power-up, on with retention.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DISABLED = 2'b00,
        MODE_RESET_PU = 2'b01,
        MODE_RETAIN = 2'b10
    } mode_t;

    // ------------------------------------------------------------------------
    // Controller states.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } state_t;

    // ------------------------------------------------------------------------
    // Reference output bundle handed to the source selectors.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] value;
        logic active;
        logic at_min;
        logic at_max;
    } ref_out_t;

endpackage

// ### motpot_rate_gen.sv
/*
 * Step pulse generator for the reference counter.
 * Assumes the caller holds i_run only while a single direction is commanded.
 */
`include "motpot_params.svh"

module motpot_rate_gen #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [WIDTH-1:0] i_span,
    input wire logic [15:0] i_ramp_ms,
    output logic o_step
);
    import motpot_pkg::*;

    localparam int AW = `MOTPOT_ACC_W;
    localparam logic [AW-1:0] CYC_MS = AW'(`MOTPOT_CYC_PER_MS);

    // The span must fit well inside the accumulator, or steps are lost.
    if (WIDTH < 1 || WIDTH >= AW) begin : g_bad_width
        $error("WIDTH must be positive and narrower than the accumulator.");
    end

    logic [AW-1:0] acc_q;
    logic [AW-1:0] ramp_cyc;
    logic [AW-1:0] acc_sum;

    // ------------------------------------------------------------------------
    // Rate accumulator
    // ------------------------------------------------------------------------
    // Over one full ramp time exactly span steps are issued.
    assign ramp_cyc = AW'(i_ramp_ms) * CYC_MS;
    assign acc_sum = acc_q + AW'(i_span);

    // The accumulator restarts whenever motion stops, so no stale step leaks.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q <= '0;
            o_step <= 1'b0;
        end else if (!i_run) begin
            acc_q <= '0;
            o_step <= 1'b0;
        end else if (acc_sum >= ramp_cyc) begin
            acc_q <= acc_sum - ramp_cyc;
            o_step <= 1'b1;
        end else begin
            acc_q <= acc_sum;
            o_step <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_no_step_idle;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_run |=> !o_step;
    endproperty
    a_no_step_idle: assert property (p_no_step_idle)
        else $error("Step issued while not running.");

    property p_acc_bounded;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_run && ramp_cyc != '0 && $stable(ramp_cyc))
            |=> acc_q < $past(ramp_cyc);
    endproperty
    a_acc_bounded: assert property (p_acc_bounded)
        else $error("Rate accumulator exceeded the ramp length.");
endmodule

// ### motpot_ref_selector.sv
/*
 * Behavioural model of the reference source selector that consumes the
 * counter output. Assumes the same clock and reset as the counter.
 */
module motpot_ref_selector (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire motpot_pkg::ref_out_t i_ref,
    output logic [15:0] o_sel_ref
);
    timeunit 1ns;
    timeprecision 1ns;
    import motpot_pkg::*;

    // ------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------
    // The selector takes the count only while the counter reports active.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sel_ref <= 16'h0000;
        end else if (i_ref.active) begin
            o_sel_ref <= i_ref.value;
        end
    end
endmodule

// ### ramped_updown_reference_counter_tb_top.sv
/*
 * Self-checking bench for the ramped up/down reference counter.
 * Assumes the counter and the selector model are compiled before it.
 */
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    err_count++; $display("ERROR %0t got %h exp %h", $time, got, exp); end end

module ramped_updown_reference_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import motpot_pkg::*;

    typedef struct {
        logic [15:0] init;
        logic up;
        logic down;
        logic [15:0] exp;
    } row_t;

    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_up = 1'b0;
    logic i_down = 1'b0;
    logic i_power_up = 1'b0;
    mode_t i_mode = MODE_DISABLED;
    logic [15:0] i_init = 16'h0018;
    logic [15:0] i_min = 16'h0010;
    logic [15:0] i_max = 16'h0020;
    logic [15:0] i_ramp_ms = 16'h0000;
    ref_out_t o_ref;
    logic [15:0] sel_ref;
    logic [15:0] load_exp;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    row_t rows[5] = '{
        '{16'h0018, 1'b1, 1'b0, 16'h0020},
        '{16'h0018, 1'b0, 1'b1, 16'h0010},
        '{16'h0018, 1'b1, 1'b1, 16'h0018},
        '{16'h0018, 1'b0, 1'b0, 16'h0018},
        '{16'h0030, 1'b0, 1'b0, 16'h0020}
    };

    // ------------------------------------------------------------------
    // Clock, instances and hang guard
    // ------------------------------------------------------------------
    // The clock toggles every 5 ns for a 100 MHz rate.
    always #5 i_clk = ~i_clk;

    motpot_counter u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_up(i_up), .i_down(i_down),
        .i_mode(i_mode), .i_power_up(i_power_up), .i_init(i_init),
        .i_min(i_min), .i_max(i_max), .i_ramp_ms(i_ramp_ms), .o_ref(o_ref)
    );

    motpot_ref_selector u_sel (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ref(o_ref), .o_sel_ref(sel_ref)
    );

    // A stuck run is cut short well past the expected length.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Inputs change only at falling edges.
    task automatic tick(int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Disables, checks the idle flag, then enables with a new start value.
    task automatic enable(mode_t m, logic [15:0] init);
        i_mode = MODE_DISABLED;
        tick(3);
        `CHK(o_ref.active, 1'b0)
        i_init = init;
        i_mode = m;
        tick(3);
    endtask

    // Drives the count to its top, then ends a power cycle.
    task automatic power(mode_t m, logic [15:0] exp);
        enable(m, 16'h0018);
        i_up = 1'b1;
        tick(40);
        i_up = 1'b0;
        tick(4);
        i_power_up = 1'b1;
        tick(1);
        i_power_up = 1'b0;
        tick(1);
        `CHK(o_ref.value, exp)
        $display("power cycle test mode %0d done", m);
    endtask

    // Measures the cycles between two successive steps in one direction.
    task automatic rate(logic u);
        int n;
        logic [15:0] v;
        i_up = u;
        i_down = !u;
        for (int k = 0; k < 2; k++) begin
            v = o_ref.value;
            n = 0;
            while (o_ref.value === v && n < 3000) begin
                tick(1);
                n++;
            end
        end
        `CHK(n, 1000)
        i_up = 1'b0;
        i_down = 1'b0;
        tick(4);
        $display("rate test direction %0d done", u);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        tick(2);
        `CHK(o_ref.value, 16'h0000)
        `CHK(o_ref.active, 1'b0)
        // Six rising edges pass under reset before it is let go.
        tick(4);
        i_rst_n = 1'b1;
        $display("reset test done");
        // Each row reloads the start value, then holds its commands.
        foreach (rows[k]) begin
            enable(MODE_RESET_PU, rows[k].init);
            load_exp = (rows[k].init > i_max) ? i_max : rows[k].init;
            `CHK(o_ref.value, load_exp)
            `CHK(o_ref.active, 1'b1)
            i_up = rows[k].up;
            i_down = rows[k].down;
            tick(40);
            `CHK(o_ref.value, rows[k].exp)
            `CHK(o_ref.at_max, rows[k].exp === i_max)
            `CHK(o_ref.at_min, rows[k].exp === i_min)
            `CHK(sel_ref, rows[k].exp)
            i_up = 1'b0;
            i_down = 1'b0;
            tick(4);
            $display("row %0d done", k);
        end
        power(MODE_RESET_PU, 16'h0018);
        power(MODE_RETAIN, 16'h0020);
        // A span of 100 over a 1 ms ramp gives one step every 1000 cycles.
        i_max = 16'h0074;
        i_ramp_ms = 16'h0001;
        enable(MODE_RESET_PU, 16'h0040);
        rate(1'b1);
        rate(1'b0);
        // A cold reset in mid-run clears the count.
        i_rst_n = 1'b0;
        tick(2);
        `CHK(o_ref.value, 16'h0000)
        `CHK(o_ref.active, 1'b0)
        i_rst_n = 1'b1;
        // With the mode still on, the start value comes back two edges on.
        tick(2);
        `CHK(o_ref.value, 16'h0040)
        `CHK(o_ref.active, 1'b1)
        $display("mid-run reset test done");
        close_out();
    end
endmodule
